// *** core/lamp_ctrl.sv ***
// Per-port lamp control: configuration register and three lamp drivers.
`timescale 1ns/10ps
`default_nettype none
module lamp_ctrl #(
  parameter int MS_CYCLES = lamp_pkg::MS_CYCLES,
  parameter int FAST_HALF_MS = 50,
  parameter int SLOW_HALF_MS = 250
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Management register access.
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  // Port conditions.
  input wire lamp_pkg::port_status_s port_status,
  // Lamp drivers, high lights the lamp.
  output logic [2:0] lamp_on
);

  //********************************************************************
  // Millisecond tick and blink phases
  //********************************************************************

  localparam int DW = $clog2(MS_CYCLES);

  logic [DW-1:0] div; // Cycles into the current millisecond.
  logic [DW-1:0] next_div;
  logic tick_ms; // One-cycle pulse per millisecond.
  logic [9:0] fast_cnt; // Milliseconds into the fast half period.
  logic [9:0] next_fast_cnt;
  logic [9:0] slow_cnt; // Milliseconds into the slow half period.
  logic [9:0] next_slow_cnt;
  logic fast_ph; // Fast blink phase.
  logic next_fast_ph;
  logic slow_ph; // Slow blink phase.
  logic next_slow_ph;

  // Divider and blink counters advance together.
  always_comb begin
    tick_ms = (div == DW'(MS_CYCLES - 1));
    next_div = tick_ms ? '0 : div + DW'(1);
    next_fast_cnt = fast_cnt;
    next_fast_ph = fast_ph;
    next_slow_cnt = slow_cnt;
    next_slow_ph = slow_ph;
    if (tick_ms) begin
      if (fast_cnt == 10'(FAST_HALF_MS - 1)) begin
        next_fast_cnt = '0;
        next_fast_ph = ~fast_ph;
      end else begin
        next_fast_cnt = fast_cnt + 10'h001;
      end
      if (slow_cnt == 10'(SLOW_HALF_MS - 1)) begin
        next_slow_cnt = '0;
        next_slow_ph = ~slow_ph;
      end else begin
        next_slow_cnt = slow_cnt + 10'h001;
      end
    end
  end

  // Registers only.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div <= '0;
      fast_cnt <= '0;
      slow_cnt <= '0;
      fast_ph <= 1'b0;
      slow_ph <= 1'b0;
    end else begin
      div <= next_div;
      fast_cnt <= next_fast_cnt;
      slow_cnt <= next_slow_cnt;
      fast_ph <= next_fast_ph;
      slow_ph <= next_slow_ph;
    end
  end

  //********************************************************************
  // Configuration register
  //********************************************************************

  lamp_pkg::lamp_cfg_s cfg; // The lamp configuration register.
  lamp_pkg::lamp_cfg_s next_cfg;
  logic [15:0] next_rdata;
  logic cfg_hit; // Access addresses this register.

  // Every bit is writable; bit zero is stored but steers nothing.
  always_comb begin
    cfg_hit = (mgmt_addr == lamp_pkg::LAMP_CFG_ADDR);
    next_cfg = cfg;
    if (mgmt_wr && cfg_hit) begin
      next_cfg = lamp_pkg::lamp_cfg_s'(mgmt_wdata);
    end
    // Other addresses belong to other registers and read as zero here.
    next_rdata = cfg_hit ? 16'(cfg) : 16'h0000;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg <= lamp_pkg::CFG_RESET;
      mgmt_rdata <= 16'h0000;
    end else begin
      cfg <= next_cfg;
      mgmt_rdata <= next_rdata;
    end
  end

  //********************************************************************
  // Lamp drivers
  //********************************************************************

  logic [3:0] sel [3]; // Selector of each lamp.
  logic [7:0] period_ms; // Chosen stretch period.
  logic [2:0] next_lamp;
  lamp_pkg::port_status_s st;

  assign sel[0] = cfg.first_lamp_source_sel;
  assign sel[1] = cfg.second_lamp_source_sel;
  assign sel[2] = cfg.third_lamp_source_sel;
  assign st = port_status;

  // period field decode
  // The unused field code falls back to the longest period.
  always_comb begin
    case (cfg.stretch_period_sel)
      lamp_pkg::PER_30: period_ms = lamp_pkg::STRETCH_30_MS;
      lamp_pkg::PER_60: period_ms = lamp_pkg::STRETCH_60_MS;
      lamp_pkg::PER_100: period_ms = lamp_pkg::STRETCH_100_MS;
      default: period_ms = lamp_pkg::STRETCH_100_MS;
    endcase
  end

  for (genvar i = 0; i < 3; i++) begin : g_lamp
    lamp_pkg::lamp_mode_e mode;
    logic evt; // Event feeding the stretcher.
    logic str_on; // Stretching applies to this lamp.
    logic act; // Stretched event.

    always_comb begin
      mode = lamp_pkg::decode_mode(i, sel[i]);
      str_on = lamp_pkg::is_combined(mode) | cfg.stretch_en;
      case (mode)
        lamp_pkg::M_TX: evt = st.tx_evt;
        lamp_pkg::M_RX: evt = st.rx_evt;
        lamp_pkg::M_COL: evt = st.col_evt;
        lamp_pkg::M_ACT: evt = st.rx_evt | st.tx_evt;
        lamp_pkg::M_LINK_ACT: evt = st.rx_evt | st.tx_evt;
        lamp_pkg::M_LINK_RX: evt = st.rx_evt;
        lamp_pkg::M_DUP_COL: evt = st.col_evt;
        default: evt = 1'b0;
      endcase
    end

    lamp_stretch #(.CW(8)) u_stretch (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .tick_ms(tick_ms),
      .stretch_on(str_on),
      .period_ms(period_ms),
      .evt(evt),
      .active(act)
    );

    // In combined modes a stretched event flips the solid lamp off,
    // which reads as a blink against the primary condition.
    always_comb begin
      case (mode)
        lamp_pkg::M_SPEED: next_lamp[i] = st.speed_100;
        lamp_pkg::M_TX: next_lamp[i] = act;
        lamp_pkg::M_RX: next_lamp[i] = act;
        lamp_pkg::M_COL: next_lamp[i] = act;
        lamp_pkg::M_LINK: next_lamp[i] = st.link_up;
        lamp_pkg::M_DUPLEX: next_lamp[i] = st.full_duplex;
        lamp_pkg::M_ACT: next_lamp[i] = act;
        lamp_pkg::M_ON: next_lamp[i] = 1'b1;
        lamp_pkg::M_OFF: next_lamp[i] = 1'b0;
        lamp_pkg::M_FAST: next_lamp[i] = fast_ph;
        lamp_pkg::M_SLOW: next_lamp[i] = slow_ph;
        lamp_pkg::M_LINK_RX: next_lamp[i] = st.link_up & ~act;
        lamp_pkg::M_LINK_ACT: next_lamp[i] = st.link_up & ~act;
        lamp_pkg::M_DUP_COL: next_lamp[i] = st.full_duplex & ~act;
        // reserved codes keep the lamp dark
        default: next_lamp[i] = 1'b0;
      endcase
    end
  end

  // Lamp outputs are registered so they never glitch.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lamp_on <= 3'h0;
    end else begin
      lamp_on <= next_lamp;
    end
  end

  //********************************************************************
  // Checks
  //********************************************************************

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // The default disable would mute this check, since it starts in reset.
  a_cfg_reset: assert property (@(posedge clk_sys) disable iff (1'b0)
    sys_rst |=> 16'(cfg) == 16'(lamp_pkg::CFG_RESET)) else
    $error("config register not at reset value");
  a_cfg_write: assert property (mgmt_wr && cfg_hit |=>
    16'(cfg) == $past(mgmt_wdata)) else
    $error("config write not stored");
  a_speed_show: assert property (sel[0] == lamp_pkg::SEL_SPEED
    |=> lamp_on[0] == $past(st.speed_100)) else
    $error("lamp one does not follow speed");
  a_link_show: assert property (sel[1] == lamp_pkg::SEL_LINK
    |=> lamp_on[1] == $past(st.link_up)) else
    $error("lamp two does not follow link");
  a_test_forced: assert property (sel[2] == lamp_pkg::SEL_ON
    ##1 sel[2] == lamp_pkg::SEL_OFF |=> $past(lamp_on[2]) && !lamp_on[2])
    else $error("forced lamp pattern wrong");
  a_dup_col_dark: assert property (sel[1] == lamp_pkg::SEL_COMBO_D
    && !st.full_duplex |=> !lamp_on[1]) else
    $error("duplex lamp lit while half duplex");
  a_reserved_dark: assert property (g_lamp[1].mode == lamp_pkg::M_NONE
    |=> !lamp_on[1]) else
    $error("reserved code lit lamp two");
  a_stretch_hold: assert property (cfg.stretch_en
    && sel[0] == lamp_pkg::SEL_TX && st.tx_evt
    ##1 (sel[0] == lamp_pkg::SEL_TX && cfg.stretch_en) [*8] |=> lamp_on[0])
    else $error("stretched transmit event not held");
  a_no_stretch: assert property (!cfg.stretch_en
    && sel[0] == lamp_pkg::SEL_RX ##1 !cfg.stretch_en
    && sel[0] == lamp_pkg::SEL_RX |=> lamp_on[0] == $past(st.rx_evt, 2))
    else $error("unstretched receive lamp wrong");
  a_combo_stretch: assert property (!cfg.stretch_en
    && sel[0] == lamp_pkg::SEL_COMBO_C && st.link_up && st.rx_evt
    ##1 sel[0] == lamp_pkg::SEL_COMBO_C [*3] |=> !lamp_on[0]) else
    $error("combined lamp did not stretch blink");
  a_period_30: assert property (cfg.stretch_period_sel
    == lamp_pkg::PER_30 |-> period_ms == lamp_pkg::STRETCH_30_MS) else
    $error("wrong stretch period");

  c_tx_event: cover property (sel[0] == lamp_pkg::SEL_TX && st.tx_evt);
  c_link_rx: cover property (sel[2] == lamp_pkg::SEL_COMBO_C
    && st.link_up && st.rx_evt);
  c_fast_blink: cover property (sel[0] == lamp_pkg::SEL_FAST
    && $rose(lamp_on[0]));

endmodule
`default_nettype wire

// *** common/lamp_pkg.sv ***
// Shared types, constants and decoding for the port lamp control block.
//**********************************************************************
// Overview of operation
// - Lamp one selector, bits 15:12, resets speed.
// - Lamp two selector, bits 11:8, resets link.
// - Codes 0-3: speed, transmit, receive, collision.
// - Codes 4,5,7: link, duplex, stretched activity.
// - Codes 8-11: on, off, fast, slow blink.
// - Code 12: link solid, receive event toggles.
// - Duplex solid, collision toggles; lamp two 13.
// - Lamp three bits 7:4; 13 link+activity, 14 duplex+collision.
// - Period field bits 3:2: 30/60/100 ms.
// - Bit one enables stretching, resets to one.
// - Combined codes always stretch regardless bit one.
// - Duplex lamp may linger after link loss.
//**********************************************************************
package lamp_pkg;

  // Management address of the lamp configuration register.
  localparam logic [4:0] LAMP_CFG_ADDR = 5'h14;

  // Layout of the lamp configuration register, top bit first.
  typedef struct packed {
    logic [3:0] first_lamp_source_sel;
    logic [3:0] second_lamp_source_sel;
    logic [3:0] third_lamp_source_sel;
    logic [1:0] stretch_period_sel;
    logic stretch_en;
    logic rsv0;
  } lamp_cfg_s;

  // Value after reset: speed, link, receive, 30 ms, stretching on.
  localparam lamp_cfg_s CFG_RESET = '{4'h0, 4'h4, 4'h2, 2'h0,
                                       1'b1, 1'b0};

  // Port conditions handed in by the port's own logic.
  typedef struct packed {
    logic speed_100;
    logic link_up;
    logic full_duplex;
    logic tx_evt;
    logic rx_evt;
    logic col_evt;
  } port_status_s;

  // Selector codes.
  localparam logic [3:0] SEL_SPEED = 4'h0;
  localparam logic [3:0] SEL_TX = 4'h1;
  localparam logic [3:0] SEL_RX = 4'h2;
  localparam logic [3:0] SEL_COL = 4'h3;
  localparam logic [3:0] SEL_LINK = 4'h4;
  localparam logic [3:0] SEL_DUPLEX = 4'h5;
  localparam logic [3:0] SEL_ACT = 4'h7;
  localparam logic [3:0] SEL_ON = 4'h8;
  localparam logic [3:0] SEL_OFF = 4'h9;
  localparam logic [3:0] SEL_FAST = 4'ha;
  localparam logic [3:0] SEL_SLOW = 4'hb;
  localparam logic [3:0] SEL_COMBO_C = 4'hc;
  localparam logic [3:0] SEL_COMBO_D = 4'hd;
  localparam logic [3:0] SEL_COMBO_E = 4'he;

  // Period field codes.
  localparam logic [1:0] PER_30 = 2'h0;
  localparam logic [1:0] PER_60 = 2'h1;
  localparam logic [1:0] PER_100 = 2'h2;

  // Stretch periods in milliseconds.
  localparam logic [7:0] STRETCH_30_MS = 8'h1e;
  localparam logic [7:0] STRETCH_60_MS = 8'h3c;
  localparam logic [7:0] STRETCH_100_MS = 8'h64;

  // Clock period and the millisecond tick derived from it.
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  // What a lamp shows.
  typedef enum logic [3:0] {
    M_SPEED, M_TX, M_RX, M_COL, M_LINK, M_DUPLEX, M_ACT, M_ON,
    M_OFF, M_FAST, M_SLOW, M_LINK_RX, M_LINK_ACT, M_DUP_COL, M_NONE
  } lamp_mode_e;

  // Turns a lamp index and its selector into a display mode.
  function automatic lamp_mode_e decode_mode(input int idx,
                                             input logic [3:0] sel);
    lamp_mode_e m;
    m = M_NONE;
    case (sel)
      SEL_SPEED: m = M_SPEED;
      SEL_TX: m = M_TX;
      SEL_RX: m = M_RX;
      SEL_COL: m = M_COL;
      SEL_LINK: m = M_LINK;
      SEL_DUPLEX: m = M_DUPLEX;
      SEL_ACT: m = M_ACT;
      SEL_ON: m = M_ON;
      SEL_OFF: m = M_OFF;
      SEL_FAST: m = M_FAST;
      SEL_SLOW: m = M_SLOW;
      SEL_COMBO_C: m = M_LINK_RX;
      // Lamp two keeps duplex+collision here, lamp three link+activity.
      SEL_COMBO_D: m = (idx == 1) ? M_DUP_COL :
                       (idx == 2) ? M_LINK_ACT : M_NONE;
      // Lamp two has no meaning for this code.
      SEL_COMBO_E: m = (idx == 1) ? M_NONE : M_DUP_COL;
      default: m = M_NONE;
    endcase
    return m;
  endfunction

  // True for modes whose events are stretched regardless of bit one.
  function automatic logic is_combined(input lamp_mode_e m);
    return (m == M_LINK_RX) || (m == M_LINK_ACT) || (m == M_DUP_COL);
  endfunction

endpackage

// *** core/lamp_stretch.sv ***
// Event stretcher for one lamp, counting in millisecond ticks.
`timescale 1ns/10ps
`default_nettype none
module lamp_stretch #(
  parameter int CW = 8
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Timing and control.
  input wire logic tick_ms,
  input wire logic stretch_on,
  input wire logic [CW-1:0] period_ms,
  // Event in, stretched event out.
  input wire logic evt,
  output logic active
);

  logic [CW-1:0] cnt; // Milliseconds still to hold.
  logic [CW-1:0] next_cnt;
  logic next_active;

  // One extra tick is loaded so the hold is never short of the period,
  // at the cost of up to one millisecond too long.
  always_comb begin
    next_cnt = cnt;
    if (!stretch_on) begin
      next_cnt = '0;
    end else if (evt) begin
      next_cnt = period_ms + CW'(1);
    end else if (tick_ms && cnt != '0) begin
      next_cnt = cnt - CW'(1);
    end
    next_active = evt | (stretch_on && next_cnt != '0);
  end

  // Registers only.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt <= '0;
      active <= 1'b0;
    end else begin
      cnt <= next_cnt;
      active <= next_active;
    end
  end

endmodule
`default_nettype wire

// *** tb/lamp_board.sv ***
// Board lamp model that counts how often each lamp lights up.
`timescale 1ns/10ps
`default_nettype none
module lamp_board (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Lamp drivers from the block, high lights a lamp.
  input wire logic [2:0] lamp_on,
  // Turn-on tallies, sixteen bits a lamp, lamp one lowest.
  output logic [47:0] rise_cnt
);
  // Lamp levels seen at the previous edge.
  logic [2:0] prev;

  // A lamp keeps no state; the tally is only for judging blink rates.
  always_ff @(posedge clk_sys) begin
    prev <= lamp_on;
    for (int i = 0; i < 3; i++) begin
      if (sys_rst) begin
        rise_cnt[i*16 +: 16] <= 16'h0;
      end else if (lamp_on[i] && !prev[i]) begin
        rise_cnt[i*16 +: 16] <= rise_cnt[i*16 +: 16] + 16'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/port_led_indicator_control_test.sv ***
// Self-checking bench for the port lamp control block.
`timescale 1ns/10ps
`default_nettype none
module port_led_indicator_control_test;
  localparam logic [4:0] CFG = lamp_pkg::LAMP_CFG_ADDR;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] mgmt_addr = 5'h0;
  logic mgmt_wr = 1'b0;
  logic [15:0] mgmt_wdata = 16'h0;
  logic [15:0] mgmt_rdata;
  lamp_pkg::port_status_s st = '0;
  logic [2:0] lamp_on;
  logic [47:0] rise_cnt;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;

  // Short millisecond tick keeps the stretch periods cheap to simulate.
  lamp_ctrl #(.MS_CYCLES(4), .FAST_HALF_MS(2), .SLOW_HALF_MS(4)) dut (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .mgmt_addr(mgmt_addr),
    .mgmt_wr(mgmt_wr),
    .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata),
    .port_status(st),
    .lamp_on(lamp_on)
  );

  lamp_board board (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .lamp_on(lamp_on),
    .rise_cnt(rise_cnt)
  );

  // 200 MHz clock.
  always #2.5 clk_sys = ~clk_sys;

  //**********************************************************
  // Helpers
  //**********************************************************
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole run needs well under this.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waits n edges and lands 1 ns after the last, where all drives happen.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    mgmt_addr = a;
    mgmt_wr = 1'b1;
    mgmt_wdata = d;
    tick(1);
    mgmt_wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
    mgmt_addr = a;
    tick(2);
    d = mgmt_rdata;
  endtask

  // One-cycle event: 0 transmit, 1 receive, 2 collision.
  task automatic pulse(input int k);
    st.tx_evt = (k == 0);
    st.rx_evt = (k == 1);
    st.col_evt = (k == 2);
    tick(1);
    st.tx_evt = 1'b0;
    st.rx_evt = 1'b0;
    st.col_evt = 1'b0;
  endtask

  function automatic logic cont_exp(input logic [3:0] c);
    case (c)
      4'h0: return st.speed_100;
      4'h4: return st.link_up;
      4'h5: return st.full_duplex;
      4'h8: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  //**********************************************************
  // Scenarios
  //**********************************************************
  // reset and reserved bit.
  task automatic t_regs();
    logic [15:0] d;
    reg_rd(CFG, d);
    chk("cfg reset", d, 16'h0422);
    reg_wr(5'h13, 16'hffff);
    reg_rd(5'h13, d);
    chk("unmapped read", d, 16'h0);
    reg_rd(CFG, d);
    chk("cfg untouched", d, 16'h0422);
    reg_wr(CFG, 16'h8423);
    reg_rd(CFG, d);
    chk("bit zero kept", d, 16'h8423);
    tick(2);
    chk("forced on", {13'h0, lamp_on}, 16'h1);
  endtask

  // continuous displays on all three lamps.
  task automatic t_cont();
    logic [3:0] codes [5] = '{4'h0, 4'h4, 4'h5, 4'h8, 4'h9};
    for (int s = 0; s < 2; s++) begin
      st.speed_100 = s[0];
      st.link_up = !s[0];
      st.full_duplex = s[0];
      foreach (codes[i]) begin
        reg_wr(CFG, {codes[i], codes[i], codes[i], 4'h2});
        // a lamp may linger briefly, so settle first.
        tick(4);
        chk("continuous", {13'h0, lamp_on},
            {13'h0, {3{cont_exp(codes[i])}}});
      end
    end
  endtask

  // events pass unstretched with the enable bit clear.
  task automatic t_evt();
    logic [3:0] codes [4] = '{4'h1, 4'h2, 4'h3, 4'h7};
    logic [3:0] hit [4] = '{4'h1, 4'h2, 4'h4, 4'h3};
    foreach (codes[i]) begin
      reg_wr(CFG, {codes[i], codes[i], codes[i], 4'h0});
      for (int k = 0; k < 3; k++) begin
        pulse(k);
        // The lamp shows the event in the second cycle after it.
        tick(1);
        chk("event shown", {13'h0, lamp_on},
            {13'h0, {3{hit[i][k]}}});
        tick(1);
        chk("event gone", {13'h0, lamp_on}, 16'h0);
      end
    end
  endtask

  // stretch lengths and restart on a new event.
  task automatic t_stretch();
    // The unused period code is expected to act as the longest period.
    int per [4] = '{30, 60, 100, 100};
    for (int p = 0; p < 4; p++) begin
      reg_wr(CFG, {12'h199, p[1:0], 2'b10});
      pulse(0);
      tick(per[p] * 4 - 2);
      chk("stretch held", {13'h0, lamp_on}, 16'h1);
      tick(12);
      chk("stretch over", {13'h0, lamp_on}, 16'h0);
    end
    reg_wr(CFG, 16'h1992);
    pulse(0);
    tick(80);
    pulse(0);
    tick(100);
    chk("restarted", {13'h0, lamp_on}, 16'h1);
    tick(40);
    chk("restart over", {13'h0, lamp_on}, 16'h0);
  endtask

  // combined displays stretch with the enable bit clear.
  task automatic t_combo();
    st.link_up = 1'b1;
    st.full_duplex = 1'b0;
    reg_wr(CFG, 16'hcdd0);
    tick(4);
    chk("half duplex", {13'h0, lamp_on}, 16'h5);
    st.full_duplex = 1'b1;
    tick(4);
    chk("primaries", {13'h0, lamp_on}, 16'h7);
    pulse(2);
    tick(20);
    chk("collision blink", {13'h0, lamp_on}, 16'h5);
    tick(130);
    chk("back solid", {13'h0, lamp_on}, 16'h7);
    pulse(1);
    tick(20);
    chk("receive blink", {13'h0, lamp_on}, 16'h2);
    reg_wr(CFG, 16'hece0);
    tick(130);
    pulse(2);
    tick(20);
    chk("lamp three dup col", {13'h0, lamp_on}, 16'h2);
    // Lamp one code 13 and lamp two code 14 have no meaning.
    reg_wr(CFG, 16'hde40);
    tick(4);
    chk("reserved dark", {13'h0, lamp_on}, 16'h4);
  endtask

  // blink rates seen by the board.
  task automatic t_blink();
    logic [47:0] r0;
    logic [15:0] f;
    logic [15:0] s;
    reg_wr(CFG, 16'hab90);
    tick(8);
    r0 = rise_cnt;
    tick(320);
    f = rise_cnt[15:0] - r0[15:0];
    s = rise_cnt[31:16] - r0[31:16];
    chk("fast blink", {15'h0, f >= 16'd19 && f <= 16'd21}, 16'h1);
    chk("slow blink", {15'h0, s >= 16'd9 && s <= 16'd11}, 16'h1);
  endtask

  // Main sequence; the bench never writes codes 6 or 15 to lamp two.
  initial begin
    tick(20);
    sys_rst = 1'b0;
    t_regs();
    t_cont();
    t_evt();
    t_stretch();
    t_combo();
    t_blink();
    close_out();
  end
endmodule
`default_nettype wire
